// *** rtl/display_instruction_decoder.v ***
// Our own choices: the placing of the registers and the strobed register port.
`include "instr_decoder_map.vh"

module display_instruction_decoder
#(
   parameter SPECIAL_MAX_WORDS = 16
)
(
   // clock and reset
   input  wire        clk,
   input  wire        sys_rst,
   // host word stream
   input  wire [15:0] in_word,
   input  wire        in_valid,
   output reg         in_ready,
   // option stores present
   input  wire        opt_graphics,
   input  wire        opt_scroll,
   input  wire        opt_status,
   input  wire        opt_font,
   input  wire        opt_periph,
   input  wire        opt_user,
   // decoded header
   output reg         hdr_valid_r,
   output reg  [7:0]  opcode_r,
   output reg  [1:0]  addr_mode_r,
   output reg         additive_r,
   output reg         rev_bg_r,
   output reg         rev_pack_r,
   output reg         special_r,
   output reg         mem_access_r,
   // operand words
   output reg         opnd_valid_r,
   output reg  [3:0]  opnd_index_r,
   output reg  [1:0]  opnd_word_r,
   output reg  [15:0] opnd_data_r,
   // special-format words
   output reg         spec_valid_r,
   output reg  [15:0] spec_data_r,
   // data bytes
   output reg         byte_valid_r,
   output reg  [7:0]  byte_data_r,
   // end of instruction
   output reg         instr_done_r,
   // register port
   input  wire [3:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // interrupt
   output reg         irq_r
);

   // register indexes
   localparam [3:0] R_STATUS = 4'h0;
   localparam [3:0] R_MASK   = 4'h1;
   localparam [3:0] R_OPCODE = 4'h2;
   localparam [3:0] R_COUNT  = 4'h3;

   // states
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_FLAG = 3'h1;
   localparam [2:0] S_OPND = 3'h2;
   localparam [2:0] S_LEN  = 3'h3;
   localparam [2:0] S_DATA = 3'h4;
   localparam [2:0] S_SPEC = 3'h5;
   localparam [2:0] S_BYT2 = 3'h6;

   reg  [2:0]  state_r;
   reg  [15:0] pflags_r;
   reg  [3:0]  pidx_r;
   reg  [2:0]  wcnt_r;
   reg         dflag_r;
   reg  [15:0] len_r;
   reg  [7:0]  held_byte_r;
   reg  [4:0]  spec_left_r;
   reg  [1:0]  status_r;
   reg  [1:0]  mask_r;
   reg  [15:0] done_cnt_r;
   wire [2:0]  nwords;

   // next set index strictly above a start point
   reg  [3:0]  next_idx;
   reg         next_found;
   integer     i;

   wire        take = in_valid & in_ready;
   wire [7:0]  opc  = in_word[`OPC_HI:`OPC_LO];

   param_word_count u_pwc
   (
      .pidx   (pidx_r),
      .nwords (nwords)
   );

   // opcode classification
   reg         opc_defined;
   reg         opc_option;
   reg         opc_have;
   reg         opc_special;
   reg  [4:0]  opc_spec_words;
   always @*
   begin
      opc_defined    = 1'b1;
      opc_option     = 1'b0;
      opc_have       = 1'b1;
      opc_special    = 1'b0;
      opc_spec_words = 5'h1;
      if (opc == `OPC_UNDEF || (opc > 8'h22 && opc != `OPC_LAST))
         opc_defined = 1'b0;
      if (opc <= 8'h07 || opc >= 8'h13)
         opc_special = (opc != 8'h22 && opc != `OPC_LAST);
      if (opc > `OPC_STD_LAST)
      begin
         opc_option = 1'b1;
         case (opc)
            8'h0e, 8'h0f, 8'h10, 8'h28: opc_have = opt_graphics;
            8'h11, 8'h12, 8'h22:        opc_have = opt_scroll;
            8'h13, 8'h14:               opc_have = opt_status;
            8'h15, 8'h21:               opc_have = opt_font;
            8'h16, 8'h17, 8'h18, 8'h19, 8'h1a: opc_have = opt_periph;
            default:                    opc_have = opt_user;
         endcase
      end
      // special words after the first; own per-opcode layout
      case (opc)
         8'h07, 8'h05: opc_spec_words = 5'h0;
         8'h01, 8'h02: opc_spec_words = 5'h2;
         default:      opc_spec_words = SPECIAL_MAX_WORDS[4:0];
      endcase
   end

   // descending scan of operand flags; the lowest set index above pidx_r wins
   always @*
   begin
      next_idx   = 4'h0;
      next_found = 1'b0;
      for (i = 15; i >= 0; i = i - 1)
         if (pflags_r[i] && i > pidx_r)
         begin
            next_idx   = i[3:0];
            next_found = 1'b1;
         end
   end

   // first set index of the flag word being taken
   reg  [3:0] first_idx;
   reg        first_found;
   always @*
   begin
      first_idx   = 4'h0;
      first_found = 1'b0;
      for (i = 15; i >= 0; i = i - 1)
         if (in_word[i])
         begin
            first_idx   = i[3:0];
            first_found = 1'b1;
         end
   end

   // main walk; one word per cycle, stalls in reset and for the second byte of each data word but the last of an odd count
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_r      <= S_IDLE;
         in_ready     <= 1'b0;
         pflags_r     <= 16'h0000;
         pidx_r       <= 4'h0;
         wcnt_r       <= 3'h0;
         dflag_r      <= 1'b0;
         len_r        <= 16'h0000;
         held_byte_r  <= 8'h00;
         spec_left_r  <= 5'h0;
         hdr_valid_r  <= 1'b0;
         opcode_r     <= 8'h00;
         addr_mode_r  <= `MODE_ABS;
         additive_r   <= 1'b0;
         rev_bg_r     <= 1'b0;
         rev_pack_r   <= 1'b0;
         special_r    <= 1'b0;
         mem_access_r <= 1'b0;
         opnd_valid_r <= 1'b0;
         opnd_index_r <= 4'h0;
         opnd_word_r  <= 2'h0;
         opnd_data_r  <= 16'h0000;
         spec_valid_r <= 1'b0;
         spec_data_r  <= 16'h0000;
         byte_valid_r <= 1'b0;
         byte_data_r  <= 8'h00;
         instr_done_r <= 1'b0;
      end
      else
      begin
         hdr_valid_r  <= 1'b0;
         opnd_valid_r <= 1'b0;
         spec_valid_r <= 1'b0;
         byte_valid_r <= 1'b0;
         instr_done_r <= 1'b0;
         in_ready     <= (state_r != S_BYT2);
         case (state_r)
            S_IDLE:
            if (take)
            begin
               opcode_r    <= opc;
               addr_mode_r <= in_word[`MODE_HI:`MODE_LO];
               additive_r  <= in_word[`ADD_BIT];
               rev_bg_r    <= in_word[`RBG_BIT];
               rev_pack_r  <= in_word[`RPK_BIT];
               dflag_r     <= in_word[`DFB_BIT];
               if (!opc_defined || (opc_option && !opc_have))
                  instr_done_r <= 1'b1;
               else if (opc_special)
               begin
                  hdr_valid_r  <= 1'b1;
                  special_r    <= 1'b1;
                  mem_access_r <= 1'b0;
                  spec_left_r  <= opc_spec_words;
                  if (opc_spec_words == 5'h0)
                     instr_done_r <= 1'b1;
                  else
                     state_r <= S_SPEC;
               end
               else
               begin
                  hdr_valid_r  <= 1'b1;
                  special_r    <= 1'b0;
                  mem_access_r <= (opc != 8'h08);
                  if (in_word[`OFB_BIT])
                     state_r <= S_FLAG;
                  else if (in_word[`DFB_BIT])
                     state_r <= S_LEN;
                  else
                     instr_done_r <= 1'b1;
               end
            end
            S_FLAG:
            if (take)
            begin
               pflags_r <= in_word;
               pidx_r   <= first_idx;
               wcnt_r   <= 3'h0;
               if (first_found)
                  state_r <= S_OPND;
               else if (dflag_r)
                  state_r <= S_LEN;
               else
               begin
                  state_r      <= S_IDLE;
                  instr_done_r <= 1'b1;
               end
            end
            S_OPND:
            if (take)
            begin
               opnd_valid_r <= 1'b1;
               opnd_index_r <= pidx_r;
               opnd_word_r  <= wcnt_r[1:0];
               opnd_data_r  <= in_word;
               if (wcnt_r + 3'h1 < nwords)
                  wcnt_r <= wcnt_r + 3'h1;
               else
               begin
                  wcnt_r <= 3'h0;
                  if (next_found)
                     pidx_r <= next_idx;
                  else if (dflag_r)
                     state_r <= S_LEN;
                  else
                  begin
                     state_r      <= S_IDLE;
                     instr_done_r <= 1'b1;
                  end
               end
            end
            S_LEN:
            if (take)
            begin
               len_r <= in_word;
               if (in_word == 16'h0000)
               begin
                  state_r      <= S_IDLE;
                  instr_done_r <= 1'b1;
               end
               else
                  state_r <= S_DATA;
            end
            S_DATA:
            if (take)
            begin
               byte_valid_r <= 1'b1;
               // byte order chosen by packing flag
               byte_data_r  <= rev_pack_r ? in_word[7:0] : in_word[15:8];
               held_byte_r  <= rev_pack_r ? in_word[15:8] : in_word[7:0];
               len_r        <= len_r - 16'h0001;
               if (len_r == 16'h0001)
               begin
                  state_r      <= S_IDLE;
                  instr_done_r <= 1'b1;                     // odd count drops spare byte
               end
               else
               begin
                  state_r  <= S_BYT2;
                  in_ready <= 1'b0;
               end
            end
            S_BYT2:
            begin
               byte_valid_r <= 1'b1;
               byte_data_r  <= held_byte_r;
               len_r        <= len_r - 16'h0001;
               if (len_r == 16'h0001)
               begin
                  state_r      <= S_IDLE;
                  instr_done_r <= 1'b1;
               end
               else
                  state_r <= S_DATA;
            end
            S_SPEC:
            if (take)
            begin
               spec_valid_r <= 1'b1;
               spec_data_r  <= in_word;
               spec_left_r  <= spec_left_r - 5'h1;
               if (spec_left_r == 5'h1)
               begin
                  state_r      <= S_IDLE;
                  instr_done_r <= 1'b1;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // bit 0 illegal instruction, bit 1 instruction done
   wire illegal_ev = (state_r == S_IDLE) && take
                   && (!opc_defined || (opc_option && !opc_have));
   wire done_ev    = instr_done_r;
   wire rd_status  = reg_rd && (reg_addr == R_STATUS);

   // sticky status; a new event wins over the read clear
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         status_r   <= 2'h0;
         mask_r     <= 2'h0;
         done_cnt_r <= 16'h0000;
         irq_r      <= 1'b0;
         reg_rdata  <= 16'h0000;
      end
      else
      begin
         status_r <= (rd_status ? 2'h0 : status_r) | {done_ev, illegal_ev};
         if (reg_wr && reg_addr == R_MASK)
            mask_r <= reg_wdata[1:0];
         if (reg_wr && reg_addr == R_COUNT)
            done_cnt_r <= 16'h0000;
         else if (done_ev)
            done_cnt_r <= done_cnt_r + 16'h0001;
         irq_r <= |(((rd_status ? 2'h0 : status_r) | {done_ev, illegal_ev}) & mask_r);
         if (reg_rd)
         begin
            case (reg_addr)
               R_STATUS: reg_rdata <= {14'h0000, status_r};
               R_MASK:   reg_rdata <= {14'h0000, mask_r};
               R_OPCODE: reg_rdata <= {5'h00, state_r, opcode_r};
               R_COUNT:  reg_rdata <= done_cnt_r;
               default:  reg_rdata <= 16'h0000;
            endcase
         end
         else
            reg_rdata <= 16'h0000;
      end
   end

endmodule

// *** rtl/instr_decoder_map.vh ***
`ifndef INSTR_DECODER_MAP_VH
`define INSTR_DECODER_MAP_VH

// first-word field positions
`define OPC_HI       15
`define OPC_LO       8
`define MODE_HI      7
`define MODE_LO      6
`define ADD_BIT      5
`define RBG_BIT      4
`define RPK_BIT      3
`define OFB_BIT      1
`define DFB_BIT      0

// addressing modes
`define MODE_ABS     2'h0
`define MODE_IX1     2'h1
`define MODE_IX2     2'h2
`define MODE_REL     2'h3

// parameter indexes with fixed word counts
`define PIDX_MSK     4'h0
`define PIDX_FGD     4'h1
`define PIDX_BGD     4'h2
`define PIDX_WIN     4'h6
`define PIDX_SCN     4'h7
`define PIDX_DIM     4'h8

// opcode range classes
`define OPC_UNDEF    8'h00
`define OPC_STD_LAST 8'h0d
`define OPC_LAST     8'h28

`endif

// *** rtl/param_word_count.v ***
`include "instr_decoder_map.vh"

// words taken by each operand group, indexed by parameter index
module param_word_count
(
   // selected parameter index
   input  wire [3:0] pidx,
   // words this group occupies
   output reg  [2:0] nwords
);

   // most groups take one word; six take two words (x, y) and index 6 takes four
   always @*
   begin
      case (pidx)
         `PIDX_MSK: nwords = 3'h1;
         `PIDX_FGD: nwords = 3'h1;
         `PIDX_BGD: nwords = 3'h1;
         `PIDX_WIN: nwords = 3'h4;
         `PIDX_SCN: nwords = 3'h1;
         `PIDX_DIM: nwords = 3'h2;
         4'h3:      nwords = 3'h2;
         4'h4:      nwords = 3'h2;
         4'h5:      nwords = 3'h2;
         4'h9:      nwords = 3'h2;
         4'ha:      nwords = 3'h2;
         default:   nwords = 3'h1;
      endcase
   end

endmodule

// *** tb/display_instruction_decoder_monitor.sv ***
module display_instruction_decoder_monitor
(
   // clock and reset
   input logic        clk,
   input logic        sys_rst,
   // word stream and option presence
   input logic [15:0] in_word,
   input logic        in_valid,
   input logic        in_ready,
   input logic        opt_graphics,
   // decoded outputs
   input logic        hdr_valid_r,
   input logic [7:0]  opcode_r,
   input logic [1:0]  addr_mode_r,
   input logic        additive_r,
   input logic        rev_bg_r,
   input logic        rev_pack_r,
   input logic        special_r,
   input logic        mem_access_r,
   input logic        opnd_valid_r,
   input logic [3:0]  opnd_index_r,
   input logic [1:0]  opnd_word_r,
   input logic [15:0] opnd_data_r,
   input logic        spec_valid_r,
   input logic [15:0] spec_data_r,
   input logic        byte_valid_r,
   input logic [7:0]  byte_data_r,
   input logic        irq_r
);
   timeunit 1ns;
   timeprecision 1ps;
   // one domain, so clock and reset are given once
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_hdr_fields: assert property (hdr_valid_r |-> $past(in_valid && in_ready) &&
      {opcode_r, addr_mode_r, additive_r, rev_bg_r, rev_pack_r} == $past(in_word[15:3]))
      else $error("header fields differ from taken word");
   a_hdr_legal: assert property (hdr_valid_r |-> opcode_r != 8'h00 &&
      (opcode_r <= 8'h22 || opcode_r == 8'h28))
      else $error("undefined opcode decoded as legal");
   a_opt_store: assert property (hdr_valid_r && opcode_r inside {8'h0e, 8'h10, 8'h28}
      |-> $past(opt_graphics))
      else $error("optional opcode accepted without its store");
   a_spec_no_mem: assert property (special_r |-> !mem_access_r)
      else $error("special instruction flagged for memory access");
   a_spec_own: assert property (spec_valid_r |-> special_r &&
      $past(in_valid && in_ready) && spec_data_r == $past(in_word))
      else $error("special word not taken from stream");
   a_opnd_data: assert property (opnd_valid_r |-> !special_r &&
      $past(in_valid && in_ready) && opnd_data_r == $past(in_word))
      else $error("operand word not taken from stream");
   a_group_words: assert property (opnd_valid_r |-> opnd_word_r <=
      (opnd_index_r == 4'h6 ? 2'h3 : (opnd_index_r inside {[4'h0:4'h2], 4'h7} ? 2'h0 : 2'h1)))
      else $error("operand group too long");
   a_first_byte: assert property (byte_valid_r && $past(in_valid && in_ready) |->
      byte_data_r == ($past(rev_pack_r) ? $past(in_word[7:0]) : $past(in_word[15:8])))
      else $error("first data byte wrong");
   a_second_byte: assert property (byte_valid_r && $past(byte_valid_r) &&
      !$past(in_valid && in_ready) |-> byte_data_r ==
      ($past(rev_pack_r, 2) ? $past(in_word[15:8], 2) : $past(in_word[7:0], 2)))
      else $error("second data byte wrong");

   c_special: cover property (hdr_valid_r && special_r);
   c_packed: cover property (byte_valid_r && rev_pack_r);
   c_irq: cover property (irq_r);
endmodule

bind display_instruction_decoder display_instruction_decoder_monitor
   display_instruction_decoder_monitor_inst (.clk, .sys_rst, .in_word, .in_valid, .in_ready,
   .opt_graphics, .hdr_valid_r, .opcode_r, .addr_mode_r, .additive_r, .rev_bg_r, .rev_pack_r,
   .special_r, .mem_access_r, .opnd_valid_r, .opnd_index_r, .opnd_word_r, .opnd_data_r,
   .spec_valid_r, .spec_data_r, .byte_valid_r, .byte_data_r, .irq_r);

// *** tb/host_word_source.sv ***
module host_word_source
(
   // clock and reset
   input  logic        clk,
   input  logic        sys_rst,
   // pacing: idle cycle after each word
   input  logic        slow,
   // word handshake
   input  logic        in_ready,
   output logic [15:0] in_word = 16'h5a5a,
   output logic        in_valid = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] q[$];

   // whole 16-bit words only
   task put(input logic [15:0] w);
      q.push_back(w);
   endtask

   // hold each word until taken; an idle bus toggles so no stale word looks valid
   always @(posedge clk)
   begin
      if (sys_rst)
         in_valid <= 1'b0;
      else if (!in_valid || in_ready)
      begin
         if (q.size() > 0 && !(slow && in_valid))
         begin
            in_valid <= 1'b1;
            in_word  <= q.pop_front();
         end
         else
         begin
            in_valid <= 1'b0;
            in_word  <= ~in_word;
         end
      end
   end
endmodule

// *** tb/display_instruction_decoder_test.sv ***
module display_instruction_decoder_test;
   timeunit 1ns;
   timeprecision 1ps;
   // bench-driven inputs
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        slow = 1'b0;
   logic        opt_graphics = 1'b0;
   logic        opt_user = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   // decoder and word source outputs
   wire         in_valid, in_ready, hdr_valid_r, additive_r, rev_bg_r, rev_pack_r;
   wire         special_r, mem_access_r, opnd_valid_r, spec_valid_r, byte_valid_r;
   wire         instr_done_r, irq_r;
   wire  [1:0]  addr_mode_r, opnd_word_r;
   wire  [3:0]  opnd_index_r;
   wire  [7:0]  opcode_r, byte_data_r;
   wire  [15:0] in_word, opnd_data_r, spec_data_r, reg_rdata;
   // bookkeeping
   logic [23:0] ev[$];
   int          n_fail = 0;
   int          check_count = 0;
   int          n_done = 0;
   // header word, then expected mode, additive, background, packing
   localparam logic [20:0] rows [9] = '{{16'h0800, 5'h00}, {16'h0840, 5'h08},
      {16'h0880, 5'h10}, {16'h08c0, 5'h18}, {16'h0820, 5'h04}, {16'h0810, 5'h02},
      {16'h0808, 5'h01}, {16'h0804, 5'h00}, {16'h08f8, 5'h1f}};
   localparam logic [7:0]  bad_opc [3] = '{8'h00, 8'h23, 8'h0e};

   display_instruction_decoder display_instruction_decoder_inst (.clk, .sys_rst, .in_word,
      .in_valid, .in_ready, .opt_graphics, .opt_scroll(1'b0), .opt_status(1'b0),
      .opt_font(1'b0), .opt_periph(1'b0), .opt_user, .hdr_valid_r, .opcode_r, .addr_mode_r,
      .additive_r, .rev_bg_r, .rev_pack_r, .special_r, .mem_access_r, .opnd_valid_r,
      .opnd_index_r, .opnd_word_r, .opnd_data_r, .spec_valid_r, .spec_data_r, .byte_valid_r,
      .byte_data_r, .instr_done_r, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_r);
   host_word_source host_word_source_inst (.clk, .sys_rst, .slow, .in_ready, .in_word,
      .in_valid);

   // 100 MHz clock
   always #5 clk = ~clk;

   function automatic logic [23:0] hd(logic [7:0] o, logic [4:0] f, logic s, logic m);
      return {2'h0, o, f, s, m, 7'h00};
   endfunction
   function automatic logic [23:0] op(logic [3:0] i, logic [1:0] w, logic [15:0] d);
      return {2'h1, i, w, d};
   endfunction

   // pulses sampled mid-cycle, clear of the edge updates
   always @(negedge clk)
   begin
      if (hdr_valid_r === 1'b1)
         ev.push_back(hd(opcode_r, {addr_mode_r, additive_r, rev_bg_r, rev_pack_r},
                         special_r, mem_access_r));
      if (opnd_valid_r === 1'b1)
         ev.push_back(op(opnd_index_r, opnd_word_r, opnd_data_r));
      if (spec_valid_r === 1'b1)
         ev.push_back({8'hc0, spec_data_r});
      if (byte_valid_r === 1'b1)
         ev.push_back({16'h8000, byte_data_r});
      if (instr_done_r === 1'b1)
         n_done++;
   end

   task end_sim;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task check(input logic [23:0] seen, input logic [23:0] want);
      check_count++;
      if (seen !== want)
      begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task next_ev(input logic [23:0] want);
      check(ev.size() > 0 ? ev.pop_front() : 24'hxxxxxx, want);
   endtask

   // queue a whole instruction and wait, bounded, for its end
   task automatic run(input logic [15:0] w[$]);
      int k;
      k = n_done;
      foreach (w[i])
         host_word_source_inst.put(w[i]);
      for (int t = 0; t < 300 && n_done == k; t++)
         @(posedge clk);
      repeat (3) @(posedge clk);
      if (n_done == k)
      begin
         n_fail++;
         end_sim();
      end
   endtask

   task reg_write(input logic [3:0] a, input logic [15:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task reg_chk(input logic [3:0] a, input logic [15:0] want);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      check({8'h00, reg_rdata}, {8'h00, want});
      @(posedge clk);
   endtask

   // main sequence
   initial
   begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      reg_chk(4'h0, 16'h0000);
      reg_chk(4'h1, 16'h0000);
      reg_chk(4'h3, 16'h0000);
      reg_write(4'h1, 16'h0001);
      $display("reset test finished");
      foreach (rows[i])
      begin
         run('{rows[i][20:5]});
         next_ev(hd(8'h08, rows[i][4:0], 1'b0, 1'b0));
      end
      $display("header table finished");
      run('{16'h0903, 16'h0141, 16'h00ff, 16'h0010, 16'h0020, 16'h0030, 16'h0040,
            16'h0008, 16'h000c, 16'h0003, 16'ha1b2, 16'hc3d4});
      next_ev(hd(8'h09, 5'h00, 1'b0, 1'b1));
      next_ev(op(4'h0, 2'h0, 16'h00ff));
      for (int j = 0; j < 4; j++)
         next_ev(op(4'h6, j[1:0], 16'(16 * (j + 1))));
      next_ev(op(4'h8, 2'h0, 16'h0008));
      next_ev(op(4'h8, 2'h1, 16'h000c));
      next_ev({16'h8000, 8'ha1});
      next_ev({16'h8000, 8'hb2});
      next_ev({16'h8000, 8'hc3});
      check(24'(ev.size()), 24'h0);
      slow <= 1'b1;
      run('{16'h090b, 16'h0086, 16'h0011, 16'h0022, 16'h0005, 16'h0004, 16'ha1b2, 16'hc3d4});
      slow <= 1'b0;
      next_ev(hd(8'h09, 5'h01, 1'b0, 1'b1));
      next_ev(op(4'h1, 2'h0, 16'h0011));
      next_ev(op(4'h2, 2'h0, 16'h0022));
      next_ev(op(4'h7, 2'h0, 16'h0005));
      for (int j = 0; j < 4; j++)
         next_ev({16'h8000, 8'(32'hb2a1d4c3 >> (8 * (3 - j)))});
      $display("operand walks finished");
      run('{16'h0100, 16'h1234, 16'h5678});
      next_ev(hd(8'h01, 5'h00, 1'b1, 1'b0));
      next_ev({8'hc0, 16'h1234});
      next_ev({8'hc0, 16'h5678});
      run('{16'h0700});
      next_ev(hd(8'h07, 5'h00, 1'b1, 1'b0));
      check(24'(ev.size()), 24'h0);
      $display("special test finished");
      foreach (bad_opc[i])
      begin
         run('{{bad_opc[i], 8'h00}});
         check({23'h0, irq_r}, 24'h1);
         check(24'(ev.size()), 24'h0);
         reg_chk(4'h0, 16'h0003);
         @(posedge clk);
         check({23'h0, irq_r}, 24'h0);
      end
      opt_graphics <= 1'b1;
      run('{16'h0e00});
      next_ev(hd(8'h0e, 5'h00, 1'b0, 1'b1));
      reg_chk(4'h0, 16'h0002);
      reg_write(4'h1, 16'h0000);
      run('{16'h2300});
      check({23'h0, irq_r}, 24'h0);
      reg_chk(4'h0, 16'h0003);
      reg_chk(4'h2, 16'h0023);
      $display("illegal opcode test finished");
      reg_chk(4'h1, 16'h0000);
      reg_chk(4'h3, 16'h0012);
      reg_write(4'h3, 16'h0000);
      reg_chk(4'h3, 16'h0000);
      reg_chk(4'hf, 16'h0000);
      $display("register test finished");
      // mid-run reset with a pending interrupt must clear status, mask and count
      reg_write(4'h1, 16'h0003);
      run('{16'h2300});
      check({23'h0, irq_r}, 24'h1);
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      check({23'h0, irq_r}, 24'h0);
      sys_rst <= 1'b0;
      @(posedge clk);
      reg_chk(4'h0, 16'h0000);
      reg_chk(4'h1, 16'h0000);
      reg_chk(4'h3, 16'h0000);
      run('{16'h0800});
      next_ev(hd(8'h08, 5'h00, 1'b0, 1'b0));
      $display("second reset test finished");
      end_sim();
   end
endmodule
